// ===== logic/trig_ctrl_pkg.sv
// package: register map, field positions and constants for the trigger control block
package trig_ctrl_pkg;
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] cmd_off = 8'h04;
    localparam logic [7:0] status_off = 8'h08;
    localparam logic [7:0] length_off = 8'h0C;
    localparam logic [7:0] inhibit_off = 8'h10;
    localparam logic [7:0] delay_off = 8'h14;
    localparam logic [7:0] time_lo_off = 8'h18;
    localparam logic [7:0] time_hi_off = 8'h1C;
    localparam logic [7:0] now_lo_off = 8'h20;
    localparam logic [7:0] now_hi_off = 8'h24;
    localparam logic [7:0] latency_off = 8'h28;
    // ctrl fields
    localparam int mode_lsb = 0;
    localparam int src_lsb = 4;
    localparam int align_bit = 8;
    localparam int tod_bit = 9;
    localparam int unit_bit = 10;
    localparam int enable_bit = 11;
    // cmd fields (write one to act)
    localparam int arm_bit = 0;
    localparam int exec_bit = 1;
    localparam logic [31:0] ctrl_reset = 32'h0000_0100;
    localparam logic [31:0] latency_reset = 32'h0000_0010;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
    typedef enum logic [2:0] {
        mode_auto, mode_retrig, mode_armed_auto, mode_armed_retrig, mode_single
    } trig_mode_t;
    typedef enum logic [1:0] {src_internal, src_external, src_sync} trig_src_t;
endpackage : trig_ctrl_pkg

// ===== logic/baseband_trigger_control.sv
// baseband trigger control: modes, sources, inhibit/delay, alignment, time trigger
// How it works
// RULE1 - free-running mode runs, ignores triggers
// RULE2 - restart mode restarts waveform on trigger
// RULE3 - armed-continuous waits trigger, arm halts output
// RULE4 - armed-restart starts, restarts, arm halts
// RULE5 - one-shot runs programmed length, retriggers restart
// RULE6 - one-shot length unit is selectable
// RULE7 - length applies only in one-shot mode
// RULE8 - stopped status while waiting for trigger
// RULE9 - running status while output active
// RULE10 - time trigger when system time equals target
// RULE11 - past trigger time never fires
// RULE12 - software programs date and time fields
// RULE13 - arm halts output until next trigger
// RULE14 - internal source fires only on execute
// RULE15 - external source triggers on active edge
// RULE16 - sync input triggers on active edge
// RULE17 - aligned output suppresses latency samples
// RULE18 - unaligned output starts sample zero after latency
// RULE19 - software disables alignment for short waveforms
// RULE20 - external triggers ignored during inhibit
// RULE21 - external trigger delayed by programmed delay
// RULE22 - inhibit and delay count cycles, restart
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module baseband_trigger_control #(
    parameter int count_w = 32,
    parameter int frame_w = 16
) (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic ext_trig,
    input wire logic sync_in,
    input wire logic [63:0] sys_time,
    input wire logic [frame_w-1:0] frame_len,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic sample_valid,
    output logic [count_w-1:0] sample_index,
    output logic running
);
    logic [31:0] ctrl_reg, length_reg, inhibit_reg, delay_reg, latency_reg;
    logic [63:0] tod_reg;
    logic arm_pulse, exec_pulse;
    logic aw_full_reg, w_full_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic wr_fire;

    trig_ctrl_pkg::trig_mode_t mode;
    trig_ctrl_pkg::trig_src_t src;
    assign mode = trig_ctrl_pkg::trig_mode_t'(ctrl_reg[trig_ctrl_pkg::mode_lsb +: 3]);
    assign src = trig_ctrl_pkg::trig_src_t'(ctrl_reg[trig_ctrl_pkg::src_lsb +: 2]);

    // ---- axi4-lite write: address and data taken in either order
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
    assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awaddr_reg <= 12'h000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                awaddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg <= 1'b1;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_full_reg <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    logic wr_known;
    always_comb begin
        case (awaddr_reg[7:0])
            trig_ctrl_pkg::ctrl_off, trig_ctrl_pkg::cmd_off, trig_ctrl_pkg::length_off,
            trig_ctrl_pkg::inhibit_off, trig_ctrl_pkg::delay_off,
            trig_ctrl_pkg::time_lo_off, trig_ctrl_pkg::time_hi_off,
            trig_ctrl_pkg::latency_off: wr_known = (awaddr_reg[11:8] == 4'h0);
            default: wr_known = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_reg <= trig_ctrl_pkg::ctrl_reset;
            length_reg <= 32'h0000_0000;
            inhibit_reg <= 32'h0000_0000;
            delay_reg <= 32'h0000_0000;
            latency_reg <= trig_ctrl_pkg::latency_reset;
            tod_reg <= 64'h0000_0000_0000_0000;
            arm_pulse <= 1'b0;
            exec_pulse <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= trig_ctrl_pkg::resp_okay;
        end else begin
            arm_pulse <= 1'b0;
            exec_pulse <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? trig_ctrl_pkg::resp_okay : trig_ctrl_pkg::resp_slverr;
                if (wr_known) begin
                    case (awaddr_reg[7:0])
                        trig_ctrl_pkg::ctrl_off: ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
                        trig_ctrl_pkg::cmd_off: begin
                            arm_pulse <= wstrb_reg[0] && wdata_reg[trig_ctrl_pkg::arm_bit];
                            exec_pulse <= wstrb_reg[0] && wdata_reg[trig_ctrl_pkg::exec_bit];
                        end
                        trig_ctrl_pkg::length_off:
                            length_reg <= merge(length_reg, wdata_reg, wstrb_reg);
                        trig_ctrl_pkg::inhibit_off:
                            inhibit_reg <= merge(inhibit_reg, wdata_reg, wstrb_reg);
                        trig_ctrl_pkg::delay_off:
                            delay_reg <= merge(delay_reg, wdata_reg, wstrb_reg);
                        // date and time packed by software into one 64-bit count  RULE12
                        trig_ctrl_pkg::time_lo_off:
                            tod_reg[31:0] <= merge(tod_reg[31:0], wdata_reg, wstrb_reg);
                        trig_ctrl_pkg::time_hi_off:
                            tod_reg[63:32] <= merge(tod_reg[63:32], wdata_reg, wstrb_reg);
                        trig_ctrl_pkg::latency_off:
                            latency_reg <= merge(latency_reg, wdata_reg, wstrb_reg);
                        default: ;
                    endcase
                end
            end
        end
    end

    // ---- axi4-lite read
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= trig_ctrl_pkg::resp_okay;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= trig_ctrl_pkg::resp_okay;
            s_axi_rdata <= 32'h0000_0000;
            if (s_axi_araddr[11:8] != 4'h0) begin
                s_axi_rresp <= trig_ctrl_pkg::resp_slverr;
            end else begin
                case (s_axi_araddr[7:0])
                    trig_ctrl_pkg::ctrl_off: s_axi_rdata <= ctrl_reg;
                    trig_ctrl_pkg::cmd_off: s_axi_rdata <= 32'h0000_0000;
                    trig_ctrl_pkg::status_off: s_axi_rdata <= {31'h0000_0000, running}; // RULE8 RULE9
                    trig_ctrl_pkg::length_off: s_axi_rdata <= length_reg;
                    trig_ctrl_pkg::inhibit_off: s_axi_rdata <= inhibit_reg;
                    trig_ctrl_pkg::delay_off: s_axi_rdata <= delay_reg;
                    trig_ctrl_pkg::time_lo_off: s_axi_rdata <= tod_reg[31:0];
                    trig_ctrl_pkg::time_hi_off: s_axi_rdata <= tod_reg[63:32];
                    trig_ctrl_pkg::now_lo_off: s_axi_rdata <= sys_time[31:0];
                    trig_ctrl_pkg::now_hi_off: s_axi_rdata <= sys_time[63:32];
                    trig_ctrl_pkg::latency_off: s_axi_rdata <= latency_reg;
                    default: s_axi_rresp <= trig_ctrl_pkg::resp_slverr;
                endcase
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ---- trigger sources
    logic ext_d_reg, sync_d_reg;
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_d_reg <= 1'b0;
            sync_d_reg <= 1'b0;
        end else begin
            ext_d_reg <= ext_trig;
            sync_d_reg <= sync_in;
        end
    end
    logic ext_edge, sync_edge;
    assign ext_edge = (src == trig_ctrl_pkg::src_external) && ext_trig && !ext_d_reg; // RULE15
    assign sync_edge = (src == trig_ctrl_pkg::src_sync) && sync_in && !sync_d_reg; // RULE16

    // inhibit window and delay line, both cycle counts restarted per accepted edge
    logic [31:0] inhibit_cnt_reg, delay_cnt_reg;
    logic delay_busy_reg, ext_accept, ext_fire;
    assign ext_accept = ext_edge && (inhibit_cnt_reg == 32'h0000_0000); // RULE20
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            inhibit_cnt_reg <= 32'h0000_0000;
        end else if (ext_accept) begin
            inhibit_cnt_reg <= inhibit_reg; // RULE22
        end else if (inhibit_cnt_reg != 32'h0000_0000) begin
            inhibit_cnt_reg <= inhibit_cnt_reg - 32'h0000_0001;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            delay_cnt_reg <= 32'h0000_0000;
            delay_busy_reg <= 1'b0;
        end else if (ext_accept) begin
            delay_cnt_reg <= delay_reg; // RULE21 RULE22
            delay_busy_reg <= (delay_reg != 32'h0000_0000);
        end else if (delay_busy_reg) begin
            delay_cnt_reg <= delay_cnt_reg - 32'h0000_0001;
            if (delay_cnt_reg == 32'h0000_0001) begin
                delay_busy_reg <= 1'b0;
            end
        end
    end
    assign ext_fire = (ext_accept && delay_reg == 32'h0000_0000) ||
                      (delay_busy_reg && delay_cnt_reg == 32'h0000_0001);

    // time-of-day gate: armed only if target lies ahead when enabled
    logic tod_armed_reg, tod_on, tod_hit;
    assign tod_on = ctrl_reg[trig_ctrl_pkg::tod_bit] &&
                    (mode == trig_ctrl_pkg::mode_armed_auto || mode == trig_ctrl_pkg::mode_single);
    assign tod_hit = tod_on && tod_armed_reg && (sys_time == tod_reg); // RULE10
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            tod_armed_reg <= 1'b0;
        end else if (!tod_on) begin
            tod_armed_reg <= 1'b0;
        end else if (tod_hit) begin
            tod_armed_reg <= 1'b0;
        end else if (!tod_armed_reg && tod_reg > sys_time) begin
            tod_armed_reg <= 1'b1; // RULE11
        end
    end

    logic trig_event;
    always_comb begin
        case (src)
            trig_ctrl_pkg::src_internal: trig_event = exec_pulse; // RULE14
            trig_ctrl_pkg::src_external: trig_event = ext_fire;
            trig_ctrl_pkg::src_sync: trig_event = sync_edge;
            default: trig_event = 1'b0;
        endcase
        // with time trigger on, the target-time hit replaces the source event as the trigger
        if (tod_on) begin
            trig_event = tod_hit;
        end
    end

    // ---- sequencer
    typedef enum logic [1:0] {st_idle, st_latency, st_run} seq_state_t;
    seq_state_t state_reg;
    logic [31:0] lat_cnt_reg;
    logic [count_w-1:0] remain_reg;
    logic [count_w-1:0] shot_len;
    logic enabled, restart, halt;
    assign enabled = ctrl_reg[trig_ctrl_pkg::enable_bit];
    // unit: 0 samples, 1 whole frames  RULE6
    assign shot_len = ctrl_reg[trig_ctrl_pkg::unit_bit]
        ? count_w'(length_reg * 32'(frame_len)) : count_w'(length_reg);
    assign halt = arm_pulse && (mode == trig_ctrl_pkg::mode_armed_auto ||
                                mode == trig_ctrl_pkg::mode_armed_retrig); // RULE13
    always_comb begin
        case (mode)
            trig_ctrl_pkg::mode_auto: restart = 1'b0; // RULE1
            trig_ctrl_pkg::mode_retrig: restart = trig_event; // RULE2
            trig_ctrl_pkg::mode_armed_auto: restart = trig_event && state_reg == st_idle; // RULE3
            trig_ctrl_pkg::mode_armed_retrig: restart = trig_event; // RULE4
            trig_ctrl_pkg::mode_single: restart = trig_event; // RULE5
            default: restart = 1'b0;
        endcase
    end

    logic align;
    assign align = ctrl_reg[trig_ctrl_pkg::align_bit];
    logic is_single;
    assign is_single = (mode == trig_ctrl_pkg::mode_single);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= st_idle;
            lat_cnt_reg <= 32'h0000_0000;
            sample_index <= '0;
            remain_reg <= '0;
        end else if (!enabled || halt) begin
            state_reg <= st_idle;
            sample_index <= '0;
        end else if (restart || (state_reg == st_idle && (mode == trig_ctrl_pkg::mode_auto ||
                                 mode == trig_ctrl_pkg::mode_retrig))) begin
            // computation starts now; latency hides or delays the first samples
            state_reg <= (latency_reg == 32'h0000_0000) ? st_run : st_latency;
            lat_cnt_reg <= latency_reg;
            sample_index <= '0;
            remain_reg <= shot_len; // RULE7
        end else begin
            case (state_reg)
                st_latency: begin
                    lat_cnt_reg <= lat_cnt_reg - 32'h0000_0001;
                    if (align) begin
                        sample_index <= sample_index + 1'b1; // RULE17
                        if (is_single) begin
                            remain_reg <= remain_reg - 1'b1;
                        end
                    end
                    if (lat_cnt_reg == 32'h0000_0001) begin
                        state_reg <= (align && is_single && remain_reg <= 1) ? st_idle : st_run;
                    end
                end
                st_run: begin
                    sample_index <= sample_index + 1'b1;
                    if (is_single) begin
                        remain_reg <= remain_reg - 1'b1;
                        if (remain_reg <= 1) begin
                            state_reg <= st_idle;
                        end
                    end
                end
                default: ;
            endcase
        end
    end
    // unaligned: index 0 is emitted first, only after the latency  RULE18
    assign sample_valid = (state_reg == st_run);
    assign running = (state_reg != st_idle); // RULE9

    a_internal_exec: assert property (@(posedge core_clk) disable iff (!nrst) // RULE14
        (src == trig_ctrl_pkg::src_internal && !tod_on && !exec_pulse) |-> !trig_event)
        else $error("internal trigger without execute");
    a_inhibit_blocks: assert property (@(posedge core_clk) disable iff (!nrst) // RULE20
        (inhibit_cnt_reg != 32'h0000_0000)
        |=> inhibit_cnt_reg == $past(inhibit_cnt_reg) - 32'h0000_0001)
        else $error("inhibit window reloaded by an edge");
    a_auto_ignores: assert property (@(posedge core_clk) disable iff (!nrst) // RULE1
        (mode == trig_ctrl_pkg::mode_auto && enabled && state_reg == st_run && !halt)
        |=> state_reg == st_run)
        else $error("free-running output interrupted");
    a_arm_halts: assert property (@(posedge core_clk) disable iff (!nrst) // RULE13
        halt |=> !running)
        else $error("arm did not halt output");
    a_past_time: assert property (@(posedge core_clk) disable iff (!nrst) // RULE11
        (tod_on && !tod_armed_reg && tod_reg < sys_time) |=> !tod_armed_reg)
        else $error("past time trigger armed");
    a_unaligned_zero: assert property (@(posedge core_clk) disable iff (!nrst) // RULE18
        ($rose(sample_valid) && !align) |-> sample_index == '0)
        else $error("unaligned output not from sample zero");
    a_status_stopped: assert property (@(posedge core_clk) disable iff (!nrst) // RULE8
        (enabled && state_reg == st_idle && !restart && !halt &&
         (mode == trig_ctrl_pkg::mode_armed_auto || mode == trig_ctrl_pkg::mode_armed_retrig ||
          mode == trig_ctrl_pkg::mode_single)) |=> !running)
        else $error("stopped status wrong");
    a_ext_edge: assert property (@(posedge core_clk) disable iff (!nrst) // RULE15
        ext_edge |-> !$past(ext_trig) && ext_trig)
        else $error("external edge without rise");
    c_restart: cover property (@(posedge core_clk) disable iff (!nrst)
        mode == trig_ctrl_pkg::mode_retrig && restart && running);
    c_single_done: cover property (@(posedge core_clk) disable iff (!nrst)
        is_single && $fell(running));
    c_tod: cover property (@(posedge core_clk) disable iff (!nrst) tod_hit);
endmodule : baseband_trigger_control
`default_nettype wire

// ===== testbench/trig_source_model.sv
// far-side model: external trigger source, primary sync output and system time
`timescale 1ns/10ps
`default_nettype none
module trig_source_model (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic fire_ext,
    input wire logic fire_sync,
    output logic ext_trig,
    output logic sync_in,
    output logic [63:0] sys_time
);
    // both lines idle low; a request gives one rising edge
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            ext_trig <= 1'b0;
            sync_in <= 1'b0;
        end else begin
            ext_trig <= fire_ext;
            sync_in <= fire_sync;
        end
    end
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) sys_time <= 64'h0;
        else sys_time <= sys_time + 64'h1;
    end
endmodule : trig_source_model
`default_nettype wire

// ===== testbench/baseband_trigger_control_bench.sv
// bench: register tasks and trigger scenarios for the trigger control block
`timescale 1ns/10ps
`default_nettype none
module baseband_trigger_control_bench;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic fire_ext = 1'b0;
    logic fire_sync = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, sample_index;
    logic ext_trig, sync_in, sample_valid, running;
    logic [63:0] sys_time;
    int err_total = 0, tests_run = 0, cyc = 0;

    always #5 core_clk = ~core_clk;

    trig_source_model far (.core_clk(core_clk), .nrst(nrst), .fire_ext(fire_ext),
        .fire_sync(fire_sync), .ext_trig(ext_trig), .sync_in(sync_in), .sys_time(sys_time));

    baseband_trigger_control DUT (.core_clk(core_clk), .nrst(nrst), .ext_trig(ext_trig),
        .sync_in(sync_in), .sys_time(sys_time), .frame_len(16'h0003),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_valid(sample_valid),
        .sample_index(sample_index), .running(running));

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    // whole run needs under 1000 cycles; a hung handshake stops here
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] got;
        got = 2'b00;
        @(posedge core_clk);
        s_axi_awaddr <= {4'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (got != 2'b11) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready) begin
                got[0] = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                got[1] = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, trig_ctrl_pkg::resp_okay});
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        s_axi_araddr <= {4'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge core_clk);
        while (s_axi_arready !== 1'b1) @(posedge core_clk);
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic fire(input logic sync);
        @(posedge core_clk);
        if (sync) fire_sync <= 1'b1;
        else fire_ext <= 1'b1;
        @(posedge core_clk);
        fire_sync <= 1'b0;
        fire_ext <= 1'b0;
    endtask : fire

    // waits for sample_valid (sel 1) or running (sel 0) to reach lvl; n counts cycles
    task automatic wt(input logic sel, input logic lvl, input int lim, output int n);
        n = 0;
        while ((sel ? sample_valid : running) !== lvl && n < lim) begin
            @(posedge core_clk);
            n++;
        end
    endtask : wt

    function automatic logic [31:0] cfg(input int m, input int s, input int al, input int tod);
        cfg = 32'h0000_0800 | 32'(m) | (32'(s) << 4) | (32'(al) << 8) | (32'(tod) << 9);
    endfunction : cfg

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        rd(8'h00, d, r);
        chk("ctrl", d, trig_ctrl_pkg::ctrl_reset);
        rd(8'h28, d, r);
        chk("latency", d, trig_ctrl_pkg::latency_reset);
        rd(8'h08, d, r);
        chk("status", d, 32'h0);
        rd(8'hFC, d, r);
        chk("unmapped", {30'h0, r}, {30'h0, trig_ctrl_pkg::resp_slverr});
        wr(8'h28, 32'h4);
        wr(8'h0C, 32'h2);
        // unit 0 counts samples, unit 1 frames of three samples
        for (int u = 0; u < 2; u++) begin
            wr(8'h00, cfg(4, 0, 0, 0) | (32'(u) << 10));
            repeat (10) @(posedge core_clk);
            chk("idle", running, 0);
            wr(8'h04, 32'h2);
            wt(1, 1, 40, n);
            chk("first index", sample_index, 0);
            chk("running", running, 1);
            wt(1, 0, 40, n);
            chk("length", n, u ? 6 : 2);
            repeat (2) @(posedge core_clk);
            chk("stopped", running, 0);
        end
        wr(8'h0C, 32'h8);
        wr(8'h00, cfg(4, 0, 1, 0));
        wr(8'h04, 32'h2);
        wt(1, 1, 40, n);
        chk("aligned index", sample_index, 4);
        for (int m = 0; m < 2; m++) begin
            wr(8'h00, cfg(m, 0, 0, 0));
            wt(1, 1, 40, n);
            wr(8'h04, 32'h2);
            wt(1, 0, 12, n);
            chk("restart", n < 12, m == 1);
        end
        wr(8'h00, 32'h0);
        wr(8'h00, cfg(2, 0, 0, 0));
        repeat (10) @(posedge core_clk);
        chk("armed wait", running, 0);
        wr(8'h04, 32'h2);
        wt(0, 1, 20, n);
        chk("armed start", running, 1);
        wr(8'h04, 32'h1);
        wt(0, 0, 10, n);
        chk("arm halt", running, 0);
        wr(8'h00, 32'h0);
        wr(8'h14, 32'h6);
        wr(8'h10, 32'h28);
        wr(8'h0C, 32'hC8);
        wr(8'h00, cfg(4, 1, 0, 0));
        fire(1'b0);
        wt(0, 1, 30, n);
        chk("delay", n >= 6 && n < 30, 1);
        wt(1, 1, 40, n);
        repeat (5) @(posedge core_clk);
        fire(1'b0);
        wt(1, 0, 20, n);
        chk("inhibited", n, 20);
        repeat (20) @(posedge core_clk);
        fire(1'b0);
        wt(1, 0, 30, n);
        chk("after inhibit", n < 30, 1);
        wr(8'h00, 32'h0);
        wr(8'h00, cfg(4, 2, 0, 0));
        fire(1'b1);
        wt(0, 1, 20, n);
        chk("sync start", running, 1);
        // target set ahead of now, then behind it
        for (int p = 0; p < 2; p++) begin
            wr(8'h00, 32'h0);
            rd(8'h20, d, r);
            wr(8'h18, p ? d - 32'hA : d + 32'h64);
            wr(8'h1C, 32'h0);
            wr(8'h00, cfg(2, 0, 0, 1));
            wt(0, 1, 150, n);
            chk("time start", n > 40 && n < 150, p == 0);
        end
        close_out();
    end
endmodule : baseband_trigger_control_bench
`default_nettype wire
